// ===== inc/cmd_pkg.sv
// Package with memory map constants, access modes and cycle costs for the memory-space decoder.
package cmd_pkg;

  // Memory sizes.
  localparam int unsigned CODE_BYTES = 16384;
  localparam int unsigned RAM_BYTES  = 256;
  localparam int unsigned EXT_RAM_BYTES = 256;
  localparam int unsigned CODE_AW    = 14;

  // Address boundaries.
  localparam logic [7:0] LOW_RAM_TOP   = 8'h7f;
  localparam logic [7:0] BIT_RAM_BASE  = 8'h20;
  localparam logic [7:0] BANK_AREA_TOP = 8'h1f;

  // Configuration register and its enable field.
  localparam logic [7:0] MEMORY_CONFIG_ADDR  = 8'haf;
  localparam logic [7:0] MEMORY_CONFIG_RESET = 8'h00;
  localparam logic [1:0] EXT_RAM_ENABLE_CODE = 2'h1;

  // Program status word address and its bank select bit positions.
  localparam logic [7:0] STATUS_WORD_ADDR = 8'hd0;
  localparam int unsigned BANK_SEL_LO_BIT = 3;
  localparam int unsigned BANK_SEL_HI_BIT = 4;
  localparam logic [7:0] STACK_RESET     = 8'h07;

  // Operand access modes from the core.
  typedef enum logic [3:0] {
    MODE_NONE      = 4'h0,
    MODE_IMM_ACC   = 4'h1,
    MODE_IMM_PTR   = 4'h2,
    MODE_DIRECT    = 4'h3,
    MODE_REGISTER  = 4'h4,
    MODE_INDIRECT  = 4'h5,
    MODE_XDIRECT   = 4'h6,
    MODE_XINDIRECT = 4'h7,
    MODE_CODE_PTR  = 4'h8,
    MODE_CODE_PC   = 4'h9,
    MODE_JMP_PTR   = 4'ha,
    MODE_BIT       = 4'hb,
    MODE_PUSH      = 4'hc,
    MODE_POP       = 4'hd,
    MODE_DIR_DIR   = 4'he
  } cmd_mode_t;

  // Target memory space selected for an access.
  typedef enum logic [2:0] {
    SPACE_NONE = 3'h0,
    SPACE_RAM  = 3'h1,
    SPACE_SFR  = 3'h2,
    SPACE_EXT  = 3'h3,
    SPACE_CODE = 3'h4,
    SPACE_LIT  = 3'h5
  } cmd_space_t;

  // Bytes and core cycles per mode.
  localparam logic [1:0] BYTES_1 = 2'h1;
  localparam logic [1:0] BYTES_2 = 2'h2;
  localparam logic [1:0] BYTES_3 = 2'h3;
  localparam logic [3:0] CYC_1   = 4'h1;
  localparam logic [3:0] CYC_2   = 4'h2;
  localparam logic [3:0] CYC_3   = 4'h3;
  localparam logic [3:0] CYC_4   = 4'h4;

endpackage : cmd_pkg

// ===== rtl/cmd_decoder.sv
// Memory-space decoder: routes core operand accesses to RAM, SFR, extended RAM and flash.
`timescale 1ns/1ns
module cmd_decoder
  import cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // Access request from the core.
  input  wire logic        REQ_VALID,
  input  wire logic [3:0]  REQ_MODE,
  input  wire logic        REQ_WRITE,
  input  wire logic [7:0]  REQ_ADDR,
  input  wire logic [7:0]  REQ_DST_ADDR,
  input  wire logic [2:0]  REQ_REG_NUM,
  input  wire logic [7:0]  REQ_WDATA,
  input  wire logic        REQ_BIT_WDATA,
  input  wire logic [7:0]  REQ_LITERAL,
  // Core registers used as bases and offset.
  input  wire logic [15:0] DATA_POINTER_PAIR,
  input  wire logic [15:0] PROGRAM_COUNTER,
  input  wire logic [7:0]  ACCUMULATOR,
  // Flash write port for loading code.
  input  wire logic        FLASH_WE,
  input  wire logic [13:0] FLASH_ADDR,
  input  wire logic [7:0]  FLASH_WDATA,
  // Answer to the core.
  output logic             RSP_VALID,
  output logic [7:0]       RSP_RDATA,
  output logic             RSP_BIT,
  output logic [2:0]       RSP_SPACE,
  output logic [1:0]       RSP_BYTES,
  output logic [3:0]       RSP_CYCLES,
  output logic [15:0]      JUMP_TARGET,
  output logic             EXT_REFUSED,
  output logic [7:0]       STACK_POINTER,
  output logic [1:0]       ACTIVE_BANK
);

  cmd_mode_t  mode;
  cmd_space_t space;
  logic [7:0] ram_q   [0:RAM_BYTES-1];
  logic [7:0] ext_ram_q [0:EXT_RAM_BYTES-1];
  logic [7:0] flash_q [0:CODE_BYTES-1];
  logic [7:0] sfr_rdata;
  logic [7:0] status_word;
  logic [7:0] cfg_value;
  logic [7:0] stack_pointer_q;
  logic [7:0] rdata_q;
  logic       bit_q;
  logic       valid_q;
  logic [2:0] space_q;
  logic [1:0] bytes_q;
  logic [3:0] cycles_q;
  logic [15:0] jump_q;
  logic       refused_q;
  logic [1:0] bank;
  logic [7:0] eff_addr;
  logic [7:0] reg_addr;
  logic [7:0] ext_addr;
  logic [15:0] code_addr;
  logic       ext_on;
  logic       bit_in_ram;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic [7:0] src_value;
  logic [7:0] push_addr;
  logic       sfr_byte_we;
  logic [6:0] sfr_byte_idx;
  logic [7:0] sfr_byte_wdata;
  logic       sfr_bit_we;
  logic [6:0] sfr_rd_idx;
  logic [1:0] bytes_d;
  logic [3:0] cycles_d;

  assign mode = cmd_mode_t'(REQ_MODE);

  // Working bank from the status word selects one of the four 8-byte groups.
  assign bank     = {status_word[BANK_SEL_HI_BIT], status_word[BANK_SEL_LO_BIT]};
  assign reg_addr = {3'h0, bank, REQ_REG_NUM};
  assign eff_addr = ram_q[reg_addr];

  // Only the documented 01 pattern opens extended RAM.
  assign ext_on = (cfg_value[1:0] == EXT_RAM_ENABLE_CODE);

  // The high pointer byte is ignored; nothing ever leaves the chip.
  assign ext_addr = (mode == MODE_XDIRECT) ? DATA_POINTER_PAIR[7:0]
                                           : eff_addr;

  assign code_addr = ((mode == MODE_CODE_PC) ? PROGRAM_COUNTER : DATA_POINTER_PAIR)
                     + {8'h00, ACCUMULATOR};

  // Low bit addresses map to RAM bytes 20h-2Fh, others to SFR bytes on 8-byte boundaries.
  assign bit_in_ram = (REQ_ADDR <= LOW_RAM_TOP);
  assign bit_pos    = REQ_ADDR[2:0];
  assign bit_byte   = bit_in_ram ? (BIT_RAM_BASE + {3'h0, REQ_ADDR[7:3]})
                                 : {REQ_ADDR[7:3], 3'h0};

  assign push_addr = stack_pointer_q + 8'h01;

  // Space selection follows the addressing mode, not only the address.
  always_comb begin
    space = SPACE_NONE;
    case (mode)
      MODE_IMM_ACC, MODE_IMM_PTR: space = SPACE_LIT;
      MODE_DIRECT, MODE_DIR_DIR:
        space = (REQ_ADDR <= LOW_RAM_TOP) ? SPACE_RAM : SPACE_SFR;
      MODE_REGISTER, MODE_INDIRECT: space = SPACE_RAM;
      MODE_XDIRECT, MODE_XINDIRECT, MODE_PUSH, MODE_POP:
        space = ext_on ? SPACE_EXT : SPACE_NONE;
      MODE_CODE_PTR, MODE_CODE_PC: space = SPACE_CODE;
      MODE_JMP_PTR: space = SPACE_NONE;
      MODE_BIT: space = bit_in_ram ? SPACE_RAM : SPACE_SFR;
      default: space = SPACE_NONE;
    endcase
  end

  // Byte and cycle cost table.
  always_comb begin
    bytes_d  = BYTES_1;
    cycles_d = CYC_1;
    case (mode)
      MODE_IMM_ACC:   begin bytes_d = BYTES_2; cycles_d = CYC_2; end
      MODE_IMM_PTR:   begin bytes_d = BYTES_3; cycles_d = CYC_3; end
      MODE_DIRECT:    begin bytes_d = BYTES_2; cycles_d = CYC_2; end
      MODE_REGISTER:  begin bytes_d = BYTES_1; cycles_d = CYC_1; end
      MODE_INDIRECT:  begin bytes_d = BYTES_1; cycles_d = CYC_2; end
      MODE_XDIRECT:   begin bytes_d = BYTES_1; cycles_d = CYC_4; end
      MODE_XINDIRECT: begin bytes_d = BYTES_1; cycles_d = CYC_4; end
      MODE_CODE_PTR, MODE_CODE_PC: begin bytes_d = BYTES_1; cycles_d = CYC_4; end
      MODE_JMP_PTR:   begin bytes_d = BYTES_1; cycles_d = CYC_3; end
      MODE_BIT, MODE_PUSH, MODE_POP: begin bytes_d = BYTES_2; cycles_d = CYC_2; end
      MODE_DIR_DIR:   begin bytes_d = BYTES_3; cycles_d = CYC_3; end
      default:        begin bytes_d = BYTES_1; cycles_d = CYC_1; end
    endcase
  end

  // Source byte for reads and for the direct-to-direct copy.
  always_comb begin
    src_value = 8'h00;
    case (mode)
      MODE_IMM_ACC, MODE_IMM_PTR: src_value = REQ_LITERAL;
      MODE_DIRECT, MODE_DIR_DIR:
        src_value = (REQ_ADDR <= LOW_RAM_TOP) ? ram_q[REQ_ADDR] : sfr_rdata;
      MODE_REGISTER:  src_value = eff_addr;
      MODE_INDIRECT:  src_value = ram_q[eff_addr];
      MODE_XDIRECT, MODE_XINDIRECT: src_value = ext_ram_q[ext_addr];
      MODE_POP:       src_value = ext_ram_q[stack_pointer_q];
      MODE_CODE_PTR, MODE_CODE_PC: src_value = flash_q[code_addr[CODE_AW-1:0]];
      MODE_BIT:       src_value = bit_in_ram ? ram_q[bit_byte] : sfr_rdata;
      default:        src_value = 8'h00;
    endcase
  end

  assign sfr_rd_idx = (mode == MODE_BIT) ? bit_byte[6:0] : REQ_ADDR[6:0];

  // SFR write strobes; an indirect access never lands here.
  always_comb begin
    sfr_byte_we    = 1'b0;
    sfr_byte_idx   = REQ_ADDR[6:0];
    sfr_byte_wdata = REQ_WDATA;
    sfr_bit_we     = 1'b0;
    if (REQ_VALID) begin
      if (mode == MODE_DIRECT && REQ_WRITE && REQ_ADDR > LOW_RAM_TOP) begin
        sfr_byte_we = 1'b1;
      end else if (mode == MODE_DIR_DIR && REQ_DST_ADDR > LOW_RAM_TOP) begin
        sfr_byte_we    = 1'b1;
        sfr_byte_idx   = REQ_DST_ADDR[6:0];
        sfr_byte_wdata = src_value;
      end else if (mode == MODE_BIT && REQ_WRITE && !bit_in_ram) begin
        sfr_bit_we = 1'b1;
      end
    end
  end

  cmd_sfr_bits u_sfr (
    .clk          (CLK),
    .rst          (SYS_RST),
    .byte_we      (sfr_byte_we),
    .byte_idx     (sfr_byte_idx),
    .byte_wdata   (sfr_byte_wdata),
    .bit_we       (sfr_bit_we),
    .bit_byte_idx (bit_byte[6:0]),
    .bit_pos      (bit_pos),
    .bit_wdata    (REQ_BIT_WDATA),
    .rd_idx       (sfr_rd_idx),
    .rd_data      (sfr_rdata),
    .status_word  (status_word),
    .cfg_value    (cfg_value)
  );

  // General RAM writes; arrays carry no reset to stay mappable to block RAM.
  always_ff @(posedge CLK) begin
    if (REQ_VALID) begin
      case (mode)
        MODE_DIRECT:
          if (REQ_WRITE && REQ_ADDR <= LOW_RAM_TOP) ram_q[REQ_ADDR] <= REQ_WDATA;
        MODE_DIR_DIR:
          if (REQ_DST_ADDR <= LOW_RAM_TOP) ram_q[REQ_DST_ADDR] <= src_value;
        MODE_REGISTER:
          if (REQ_WRITE) ram_q[reg_addr] <= REQ_WDATA;
        MODE_INDIRECT:
          if (REQ_WRITE) ram_q[eff_addr] <= REQ_WDATA;
        MODE_BIT:
          if (REQ_WRITE && bit_in_ram) ram_q[bit_byte][bit_pos] <= REQ_BIT_WDATA;
        default: ;
      endcase
    end
  end

  // Extended RAM writes, gated by the enable field.
  always_ff @(posedge CLK) begin
    if (REQ_VALID && ext_on) begin
      if (REQ_WRITE && (mode == MODE_XDIRECT || mode == MODE_XINDIRECT)) begin
        ext_ram_q[ext_addr] <= REQ_WDATA;
      end else if (mode == MODE_PUSH) begin
        ext_ram_q[push_addr] <= REQ_WDATA;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (FLASH_WE) begin
      flash_q[FLASH_ADDR] <= FLASH_WDATA;
    end
  end

  // Stack pointer: pre-increment on push, post-decrement on pop.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stack_pointer_q <= STACK_RESET;
    end else if (REQ_VALID && ext_on && mode == MODE_PUSH) begin
      stack_pointer_q <= push_addr;
    end else if (REQ_VALID && ext_on && mode == MODE_POP) begin
      stack_pointer_q <= stack_pointer_q - 8'h01;
    end
  end

  // Registered answer, one cycle after the request.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      valid_q   <= 1'b0;
      rdata_q   <= 8'h00;
      bit_q     <= 1'b0;
      space_q   <= 3'h0;
      bytes_q   <= 2'h0;
      cycles_q  <= 4'h0;
      jump_q    <= 16'h0000;
      refused_q <= 1'b0;
    end else begin
      valid_q   <= REQ_VALID;
      refused_q <= REQ_VALID && !ext_on &&
                   (mode == MODE_XDIRECT || mode == MODE_XINDIRECT ||
                    mode == MODE_PUSH || mode == MODE_POP);
      if (REQ_VALID) begin
        rdata_q  <= src_value;
        bit_q    <= src_value[bit_pos];
        space_q  <= space;
        bytes_q  <= bytes_d;
        cycles_q <= cycles_d;
        if (mode == MODE_JMP_PTR) begin
          jump_q <= DATA_POINTER_PAIR + {8'h00, ACCUMULATOR};
        end
      end
    end
  end

  assign RSP_VALID     = valid_q;
  assign RSP_RDATA     = rdata_q;
  assign RSP_BIT       = bit_q;
  assign RSP_SPACE     = space_q;
  assign RSP_BYTES     = bytes_q;
  assign RSP_CYCLES    = cycles_q;
  assign JUMP_TARGET   = jump_q;
  assign EXT_REFUSED   = refused_q;
  assign STACK_POINTER = stack_pointer_q;
  assign ACTIVE_BANK   = bank;

endmodule : cmd_decoder

// ===== rtl/cmd_sfr_bits.sv
// Bit-addressable special function register store with byte and bit access.
`timescale 1ns/1ns
module cmd_sfr_bits
  import cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Byte access.
  input  wire logic       byte_we,
  input  wire logic [6:0] byte_idx,
  input  wire logic [7:0] byte_wdata,
  // Bit access.
  input  wire logic       bit_we,
  input  wire logic [6:0] bit_byte_idx,
  input  wire logic [2:0] bit_pos,
  input  wire logic       bit_wdata,
  // Read ports.
  input  wire logic [6:0] rd_idx,
  output logic      [7:0] rd_data,
  output logic      [7:0] status_word,
  output logic      [7:0] cfg_value
);

  logic [7:0] sfr_q [0:127];

  // A bit write touches only its own bit, so no read-modify-write is needed by the core.
  genvar g;
  generate
    for (g = 0; g < 128; g++) begin : g_sfr
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sfr_q[g] <= (7'(g) == MEMORY_CONFIG_ADDR[6:0]) ? MEMORY_CONFIG_RESET : 8'h00;
        end else if (byte_we && byte_idx == 7'(g)) begin
          sfr_q[g] <= byte_wdata;
        end else if (bit_we && bit_byte_idx == 7'(g)) begin
          sfr_q[g][bit_pos] <= bit_wdata;
        end
      end
    end
  endgenerate

  assign rd_data   = sfr_q[rd_idx];
  assign status_word = sfr_q[STATUS_WORD_ADDR[6:0]];
  assign cfg_value = sfr_q[MEMORY_CONFIG_ADDR[6:0]];

endmodule : cmd_sfr_bits

// ===== tb/cmd_core_model.sv
// Behavioural core model that issues operand accesses to the decoder.
`timescale 1ns/1ns
module cmd_core_model
  import cmd_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Request to the decoder.
  output logic             req_valid,
  output logic [3:0]       req_mode,
  output logic             req_write,
  output logic [7:0]       req_addr,
  output logic [7:0]       req_dst,
  output logic [2:0]       req_reg,
  output logic [7:0]       req_wdata,
  output logic             req_bit,
  output logic [7:0]       req_lit,
  output logic [15:0]      ptr_pair,
  output logic [15:0]      pc,
  output logic [7:0]       acc,
  // Answer from the decoder.
  input  wire logic        rsp_valid,
  input  wire logic [18:0] rsp_all
);
  initial begin
    {req_valid, req_mode, req_write, req_addr, req_dst, req_reg} = '0;
    {req_wdata, req_bit, req_lit, ptr_pair, pc, acc} = '0;
  end

  // One access: held over the taking edge, answer sampled at the next falling edge, half a cycle later.
  task automatic access(input logic [3:0] m, input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [18:0] r, output logic late);
    @(negedge clk);
    req_mode = m;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    // Released address and data lines flip so a stale value can never pass for a held one.
    req_addr = ~req_addr;
    req_wdata = ~req_wdata;
    r = rsp_all;
    late = (rsp_valid !== 1'b1);
  endtask : access
endmodule : cmd_core_model

// ===== tb/cmd_decoder_props.sv
// Concurrent checks on the memory-space decoder ports.
`timescale 1ns/1ns
module cmd_decoder_props
  import cmd_pkg::*;
(
  // Clock and reset.
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // Request side.
  input wire logic        REQ_VALID,
  input wire logic [3:0]  REQ_MODE,
  input wire logic [7:0]  REQ_ADDR,
  input wire logic [7:0]  REQ_LITERAL,
  input wire logic [15:0] DATA_POINTER_PAIR,
  input wire logic [7:0]  ACCUMULATOR,
  // Answer side.
  input wire logic        RSP_VALID,
  input wire logic [7:0]  RSP_RDATA,
  input wire logic [2:0]  RSP_SPACE,
  input wire logic [1:0]  RSP_BYTES,
  input wire logic [3:0]  RSP_CYCLES,
  input wire logic [15:0] JUMP_TARGET,
  input wire logic        EXT_REFUSED,
  input wire logic [7:0]  STACK_POINTER
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_answer_follows: assert property (REQ_VALID |=> RSP_VALID)
    else $error("answer missing after request");
  a_answer_has_cause: assert property (RSP_VALID |-> $past(REQ_VALID))
    else $error("answer without request");
  a_direct_cost: assert property (REQ_VALID && REQ_MODE == MODE_DIRECT |=>
    RSP_BYTES == BYTES_2 && RSP_CYCLES == CYC_2)
    else $error("direct cost wrong");
  a_direct_upper_sfr: assert property (REQ_VALID && REQ_MODE == MODE_DIRECT && REQ_ADDR[7] |=>
    RSP_SPACE == SPACE_SFR)
    else $error("upper direct address missed the register space");
  a_indirect_ram: assert property (REQ_VALID && REQ_MODE == MODE_INDIRECT |=>
    RSP_SPACE == SPACE_RAM && RSP_CYCLES == CYC_2)
    else $error("indirect access left general RAM");
  a_ext_four_cycles: assert property (REQ_VALID &&
    (REQ_MODE == MODE_XDIRECT || REQ_MODE == MODE_XINDIRECT) |=>
    EXT_REFUSED || (RSP_SPACE == SPACE_EXT && RSP_CYCLES == CYC_4))
    else $error("extended access space or cost wrong");
  a_code_read: assert property (REQ_VALID &&
    (REQ_MODE == MODE_CODE_PTR || REQ_MODE == MODE_CODE_PC) |=>
    RSP_SPACE == SPACE_CODE && RSP_CYCLES == CYC_4)
    else $error("code read space or cost wrong");
  a_jump_sum: assert property (REQ_VALID && REQ_MODE == MODE_JMP_PTR |=>
    JUMP_TARGET == $past(DATA_POINTER_PAIR) + {8'h00, $past(ACCUMULATOR)} &&
    RSP_CYCLES == CYC_3)
    else $error("jump target or cost wrong");
  a_imm_literal: assert property (REQ_VALID && REQ_MODE == MODE_IMM_ACC |=>
    RSP_RDATA == $past(REQ_LITERAL) && RSP_SPACE == SPACE_LIT)
    else $error("immediate operand not the literal");
  a_push_first: assert property (REQ_VALID && REQ_MODE == MODE_PUSH |=>
    EXT_REFUSED || STACK_POINTER == $past(STACK_POINTER) + 8'h01)
    else $error("push did not advance the stack pointer");

  c_refused: cover property (EXT_REFUSED);
  c_ext_hit: cover property (RSP_VALID && RSP_SPACE == SPACE_EXT);
  c_code_hit: cover property (RSP_VALID && RSP_SPACE == SPACE_CODE);
endmodule : cmd_decoder_props

bind cmd_decoder cmd_decoder_props u_props (
  .CLK(CLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID), .REQ_MODE(REQ_MODE),
  .REQ_ADDR(REQ_ADDR), .REQ_LITERAL(REQ_LITERAL), .DATA_POINTER_PAIR(DATA_POINTER_PAIR),
  .ACCUMULATOR(ACCUMULATOR), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
  .RSP_SPACE(RSP_SPACE), .RSP_BYTES(RSP_BYTES), .RSP_CYCLES(RSP_CYCLES),
  .JUMP_TARGET(JUMP_TARGET), .EXT_REFUSED(EXT_REFUSED), .STACK_POINTER(STACK_POINTER));

// ===== tb/testbench.sv
// Self-checking testbench for the memory-space decoder.
`timescale 1ns/1ns
module testbench;
  import cmd_pkg::*;
  localparam logic [18:0] W = 19'h5ff00;
  localparam logic [18:0] R = 19'h5ffff;
  localparam logic [18:0] B = 19'h7ff00;
  localparam logic [18:0] X = 19'h5c000;
  localparam logic [18:0] C = 19'h03f00;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        FLASH_WE = 1'b0;
  logic [13:0] FLASH_ADDR = 14'h0000;
  logic [7:0]  FLASH_WDATA = 8'h00;
  wire         req_valid, req_write, req_bit, RSP_VALID, RSP_BIT, EXT_REFUSED;
  wire  [3:0]  req_mode, RSP_CYCLES;
  wire  [7:0]  req_addr, req_dst, req_wdata, req_lit, acc, RSP_RDATA, STACK_POINTER;
  wire  [2:0]  req_reg, RSP_SPACE;
  wire  [15:0] ptr_pair, pc, JUMP_TARGET;
  wire  [1:0]  RSP_BYTES, ACTIVE_BANK;
  int          err_total = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #10 CLK = ~CLK;

  cmd_core_model core (.clk(CLK), .req_valid(req_valid), .req_mode(req_mode),
    .req_write(req_write), .req_addr(req_addr), .req_dst(req_dst), .req_reg(req_reg),
    .req_wdata(req_wdata), .req_bit(req_bit), .req_lit(req_lit), .ptr_pair(ptr_pair),
    .pc(pc), .acc(acc), .rsp_valid(RSP_VALID),
    .rsp_all({EXT_REFUSED, RSP_BIT, RSP_SPACE, RSP_BYTES, RSP_CYCLES, RSP_RDATA}));

  cmd_decoder dut (.CLK(CLK), .SYS_RST(SYS_RST), .REQ_VALID(req_valid), .REQ_MODE(req_mode),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_DST_ADDR(req_dst),
    .REQ_REG_NUM(req_reg), .REQ_WDATA(req_wdata), .REQ_BIT_WDATA(req_bit),
    .REQ_LITERAL(req_lit), .DATA_POINTER_PAIR(ptr_pair), .PROGRAM_COUNTER(pc),
    .ACCUMULATOR(acc), .FLASH_WE(FLASH_WE), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_WDATA(FLASH_WDATA), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .RSP_BIT(RSP_BIT), .RSP_SPACE(RSP_SPACE), .RSP_BYTES(RSP_BYTES),
    .RSP_CYCLES(RSP_CYCLES), .JUMP_TARGET(JUMP_TARGET), .EXT_REFUSED(EXT_REFUSED),
    .STACK_POINTER(STACK_POINTER), .ACTIVE_BANK(ACTIVE_BANK));

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // The run needs about eighty cycles; a hang is cut well after that.
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(string nm, logic [18:0] seen, logic [18:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [18:0] ex(cmd_space_t s, logic [1:0] b, logic [3:0] c,
                                     logic [7:0] d);
    return {2'b00, s, b, c, d};
  endfunction : ex

  // Masked fields are those the check does not compare for this kind of access, though the answer still drives them.
  task automatic op(string nm, logic [3:0] m, logic w, logic [7:0] a, logic [7:0] d,
                    logic [18:0] exp, logic [18:0] mask);
    logic [18:0] r;
    logic        late;
    core.access(m, w, a, d, r, late);
    if (late) begin
      err_total++;
      $display("unexpected %s: expected answer seen none", nm);
    end
    chk(nm, r & mask, exp);
  endtask : op

  task automatic flash_wr(logic [13:0] a, logic [7:0] d);
    @(negedge CLK);
    FLASH_WE = 1'b1;
    FLASH_ADDR = a;
    FLASH_WDATA = d;
    @(negedge CLK);
    FLASH_WE = 1'b0;
  endtask : flash_wr

  initial begin
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    SYS_RST = 1'b0;
    chk("reset", {8'h0, ACTIVE_BANK, RSP_VALID, STACK_POINTER}, {11'h0, STACK_RESET});
    core.ptr_pair = 16'h0155;
    op("ext_off", MODE_XDIRECT, 1'b1, 8'h00, 8'h5a, 19'h40000, X);
    op("cfg_wr", MODE_DIRECT, 1'b1, MEMORY_CONFIG_ADDR, 8'h01, ex(SPACE_SFR, BYTES_2, CYC_2, 8'h00), W);
    op("cfg_rd", MODE_DIRECT, 1'b0, MEMORY_CONFIG_ADDR, 8'h00, ex(SPACE_SFR, BYTES_2, CYC_2, 8'h01), R);
    op("dir_wr", MODE_DIRECT, 1'b1, 8'h30, 8'ha5, ex(SPACE_RAM, BYTES_2, CYC_2, 8'h00), W);
    op("reg_wr", MODE_REGISTER, 1'b1, 8'h00, 8'h30, ex(SPACE_RAM, BYTES_1, CYC_1, 8'h00), W);
    op("ind_rd", MODE_INDIRECT, 1'b0, 8'h00, 8'h00, ex(SPACE_RAM, BYTES_1, CYC_2, 8'ha5), R);
    op("reg_hi", MODE_REGISTER, 1'b1, 8'h00, 8'h90, ex(SPACE_RAM, BYTES_1, CYC_1, 8'h00), W);
    op("ind_wr", MODE_INDIRECT, 1'b1, 8'h00, 8'h3c, ex(SPACE_RAM, BYTES_1, CYC_2, 8'h00), W);
    op("sfr_rd", MODE_DIRECT, 1'b0, 8'h90, 8'h00, ex(SPACE_SFR, BYTES_2, CYC_2, 8'h00), R);
    op("ind_hi", MODE_INDIRECT, 1'b0, 8'h00, 8'h00, ex(SPACE_RAM, BYTES_1, CYC_2, 8'h3c), R);
    op("bank0", MODE_DIRECT, 1'b0, 8'h00, 8'h00, ex(SPACE_RAM, BYTES_2, CYC_2, 8'h90), R);
    op("x_wr", MODE_XDIRECT, 1'b1, 8'h00, 8'h5a, ex(SPACE_EXT, BYTES_1, CYC_4, 8'h00), W);
    op("reg_x", MODE_REGISTER, 1'b1, 8'h00, 8'h55, ex(SPACE_RAM, BYTES_1, CYC_1, 8'h00), W);
    op("xi_rd", MODE_XINDIRECT, 1'b0, 8'h00, 8'h00, ex(SPACE_EXT, BYTES_1, CYC_4, 8'h5a), R);
    op("byte21", MODE_DIRECT, 1'b1, 8'h21, 8'h00, ex(SPACE_RAM, BYTES_2, CYC_2, 8'h00), W);
    core.req_bit = 1'b1;
    op("bit_wr", MODE_BIT, 1'b1, 8'h0a, 8'h00, ex(SPACE_RAM, BYTES_2, CYC_2, 8'h00), W);
    op("bit_byte", MODE_DIRECT, 1'b0, 8'h21, 8'h00, ex(SPACE_RAM, BYTES_2, CYC_2, 8'h04), R);
    op("bit_rd", MODE_BIT, 1'b0, 8'h0a, 8'h00, ex(SPACE_RAM, BYTES_2, CYC_2, 8'h00) | 19'h20000, B);
    op("sfr_bit", MODE_BIT, 1'b1, 8'hd3, 8'h00, ex(SPACE_SFR, BYTES_2, CYC_2, 8'h00), W);
    chk("bank", {17'h0, ACTIVE_BANK}, 19'h1);
    op("reg_b1", MODE_REGISTER, 1'b1, 8'h00, 8'h11, ex(SPACE_RAM, BYTES_1, CYC_1, 8'h00), W);
    op("bank1", MODE_DIRECT, 1'b0, 8'h08, 8'h00, ex(SPACE_RAM, BYTES_2, CYC_2, 8'h11), R);
    for (int i = 0; i < 8; i++) flash_wr(14'h100 + 14'(i), 8'h70 + 8'(i));
    core.ptr_pair = 16'h0100;
    core.acc = 8'h05;
    op("code_dp", MODE_CODE_PTR, 1'b0, 8'h00, 8'h00, ex(SPACE_CODE, BYTES_1, CYC_4, 8'h75), R);
    op("jump", MODE_JMP_PTR, 1'b0, 8'h00, 8'h00, ex(SPACE_NONE, BYTES_1, CYC_3, 8'h00), C);
    chk("target", {3'h0, JUMP_TARGET}, 19'h00105);
    core.pc = 16'h0103;
    core.acc = 8'h03;
    op("code_pc", MODE_CODE_PC, 1'b0, 8'h00, 8'h00, ex(SPACE_CODE, BYTES_1, CYC_4, 8'h76), R);
    core.req_lit = 8'h99;
    op("imm_a", MODE_IMM_ACC, 1'b0, 8'h00, 8'h00, ex(SPACE_LIT, BYTES_2, CYC_2, 8'h99), R);
    op("imm_p", MODE_IMM_PTR, 1'b0, 8'h00, 8'h00, ex(SPACE_LIT, BYTES_3, CYC_3, 8'h00), W);
    core.req_dst = 8'h31;
    op("dir_dir", MODE_DIR_DIR, 1'b1, 8'h30, 8'h00, ex(SPACE_NONE, BYTES_3, CYC_3, 8'h00), C);
    op("dst_rd", MODE_DIRECT, 1'b0, 8'h31, 8'h00, ex(SPACE_RAM, BYTES_2, CYC_2, 8'ha5), R);
    op("push", MODE_PUSH, 1'b1, 8'h00, 8'h66, 19'h00000, 19'h40000);
    chk("sp", {11'h0, STACK_POINTER}, 19'h00008);
    core.ptr_pair = 16'h0008;
    op("stack_rd", MODE_XDIRECT, 1'b0, 8'h00, 8'h00, ex(SPACE_EXT, BYTES_1, CYC_4, 8'h66), R);
    op("pop", MODE_POP, 1'b0, 8'h00, 8'h00, ex(SPACE_EXT, BYTES_2, CYC_2, 8'h66), R);
    chk("sp_pop", {11'h0, STACK_POINTER}, 19'h00007);
    print_verdict();
  end
endmodule : testbench
